// ===== logic/pwpc_pkg.sv
package pwpc_pkg;
	localparam int          NCH            = 4;
	localparam int          CLK_HZ         = 50_000_000;
	localparam int          RING_HZ        = 6_000_000;
	localparam int          FRAC_HZ        = 2_000_000;
	// Fractional tick: add STEP per clock, wrap at MOD, one ring tick per wrap
	localparam logic [4:0]  TICK_STEP      = 5'(RING_HZ / FRAC_HZ);
	localparam logic [4:0]  TICK_MOD       = 5'(CLK_HZ / FRAC_HZ);
	localparam int          UNIT_US        = 10;
	localparam logic [6:0]  TICKS_PER_UNIT = 7'(UNIT_US * (RING_HZ / 1_000_000));
	localparam int          WIDTH_MIN_US   = 10;
	localparam int          PERIOD_MIN_US  = 20;
	localparam int          MAX_S          = 100;
	localparam logic [31:0] WIDTH_MIN_UNITS  = 32'(WIDTH_MIN_US / UNIT_US);
	localparam logic [31:0] PERIOD_MIN_UNITS = 32'(PERIOD_MIN_US / UNIT_US);
	localparam logic [31:0] MAX_UNITS        = 32'(MAX_S * (1_000_000 / UNIT_US));
	localparam logic [5:0]  DIV_STEPS      = 6'h20;

	localparam logic [7:0]  OFS_RISE_LO    = 8'h00;
	localparam logic [7:0]  OFS_RISE_HI    = 8'h04;
	localparam logic [7:0]  OFS_FALL_LO    = 8'h08;
	localparam logic [7:0]  OFS_FALL_HI    = 8'h0C;
	localparam logic [7:0]  OFS_RES_LO     = 8'h10;
	localparam logic [7:0]  OFS_RES_HI     = 8'h14;
	localparam logic [7:0]  CH_STRIDE      = 8'h20;
	localparam logic [7:0]  OFS_CTRL       = 8'h80;
	localparam logic [7:0]  OFS_STATUS     = 8'h84;
	localparam logic [7:0]  OFS_MASK       = 8'h88;
	localparam logic [7:0]  OFS_BUDGET     = 8'h8C;

	typedef struct packed {
		logic [3:0] period_mode;
		logic [3:0] enable;
	} pwpc_ctrl_t;

	typedef struct packed {
		logic [3:0] range_err;
		logic [3:0] conflict;
		logic [3:0] measure_flag;
	} pwpc_evt_t;

	typedef struct packed {
		logic [31:0] rise;
		logic [31:0] fall;
		logic [31:0] result;
	} pwpc_vals_t;

	localparam pwpc_ctrl_t CTRL_RESET = 8'h00;
	localparam pwpc_evt_t  EVT_RESET  = 12'h000;
endpackage : pwpc_pkg

// ===== logic/pwpc_chan.sv
`timescale 1ns/100ps
module pwpc_chan
(
	input  wire logic              clock_i,
	input  wire logic              rst_n_i,
	input  wire logic              ce_i,
	input  wire logic              clear_i,
	input  wire logic              active_i,
	input  wire logic              period_mode_i,
	input  wire logic              level_i,
	input  wire logic [31:0]       ring_i,
	output pwpc_pkg::pwpc_vals_t   vals_o,
	output logic                   done_o,
	output logic                   range_o
);
	import pwpc_pkg::*;

	typedef enum logic [1:0] {CH_IDLE = 2'b00, CH_DIV = 2'b01} pwpc_chst_t;

	pwpc_chst_t  state;
	logic        level_q;
	logic        have_rise;
	logic [31:0] span;
	logic [31:0] quot;
	logic [6:0]  rem;
	logic [5:0]  steps;

	wire         rise_edge  = active_i & level_i & ~level_q;
	wire         fall_edge  = active_i & ~level_i & level_q;
	// Same difference serves both modes: in period mode the stored rise is the previous one
	wire [31:0]  edge_span  = ring_i - vals_o.rise;
	wire         start      = (state == CH_IDLE) & ~clear_i & have_rise
		& (period_mode_i ? rise_edge : fall_edge);
	wire [6:0]   rem_sh     = {rem[5:0], quot[31]};
	wire         rem_ge     = rem_sh >= TICKS_PER_UNIT;
	wire [6:0]   next_rem   = rem_ge ? rem_sh - TICKS_PER_UNIT : rem_sh;
	wire [31:0]  next_quot  = {quot[30:0], rem_ge};
	wire [31:0]  min_units  = period_mode_i ? PERIOD_MIN_UNITS : WIDTH_MIN_UNITS;
	wire         next_range = (next_quot < min_units) | (next_quot > MAX_UNITS);

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			state     <= CH_IDLE;
			level_q   <= 1'b0;
			have_rise <= 1'b0;
			vals_o    <= '0;
			span      <= 32'h0;
			quot      <= 32'h0;
			rem       <= 7'h00;
			steps     <= 6'h00;
			done_o    <= 1'b0;
			range_o   <= 1'b0;
		end
		else if (ce_i)
		begin
			level_q <= level_i;
			done_o  <= 1'b0;
			range_o <= 1'b0;
			if (clear_i)
			begin
				vals_o    <= '0;
				have_rise <= 1'b0;
				state     <= CH_IDLE;
			end
			else
			begin
				if (rise_edge)
				begin
					vals_o.rise <= ring_i;
					have_rise   <= 1'b1;
				end
				if (fall_edge)
					vals_o.fall <= ring_i;
				case (state)
					CH_IDLE:
						if (start)
						begin
							span  <= edge_span;
							quot  <= edge_span;
							rem   <= 7'h00;
							steps <= DIV_STEPS;
							state <= CH_DIV;
						end
					CH_DIV:
					begin
						// Shift-subtract divide by ticks per 10 us unit, one bit per cycle
						rem   <= next_rem;
						quot  <= next_quot;
						steps <= steps - 6'h01;
						if (steps == 6'h01)
						begin
							vals_o.result <= next_quot;
							range_o       <= next_range;
							done_o        <= 1'b1;
							state         <= CH_IDLE;
						end
					end
					default:
						state <= CH_IDLE;
				endcase
			end
		end
	end

	div_result_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		done_o |-> (64'(vals_o.result) * 64'(TICKS_PER_UNIT) <= 64'(span))
			&& (64'(span) < 64'(vals_o.result) * 64'(TICKS_PER_UNIT) + 64'(TICKS_PER_UNIT)))
		else $error("result is not span over ticks per unit");
	rise_latch_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		ce_i && rise_edge && !clear_i |=> vals_o.rise == $past(ring_i))
		else $error("rise timestamp not latched");
	fall_latch_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		ce_i && fall_edge && !clear_i |=> vals_o.fall == $past(ring_i))
		else $error("fall timestamp not latched");
	clear_vals_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		ce_i && clear_i |=> vals_o == '0 && state == CH_IDLE)
		else $error("values not cleared on run start");
	span_start_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		ce_i && start |=> span == $past(ring_i) - $past(vals_o.rise) && state == CH_DIV)
		else $error("span not taken from timestamps");
	range_flag_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		done_o && !range_o && $past(ce_i) |-> vals_o.result <= MAX_UNITS
			&& vals_o.result >= ($past(period_mode_i) ? PERIOD_MIN_UNITS : WIDTH_MIN_UNITS))
		else $error("out of range result not flagged");
endmodule : pwpc_chan

// ===== logic/pwpc_top.sv
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/100ps
// Behaviour
// - results counted in 10 us units, four channels
// - latch ring counter at rising and falling edges
// - per channel flag, mode bit, three word pairs
// - clear all values on stop-to-run
// - width range 10 us to 100 s
// - period range 20 us to 100 s
// - no counter sharing; interrupt sharing allowed
// - active channels shrink counter frequency budget
module pwpc_top
#(
	parameter logic [15:0] HSC_FULL_KHZ   = 16'h003C,
	parameter logic [15:0] MEAS_SHARE_KHZ = 16'h000A
)
(
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	input  wire logic        run_i,
	input  wire logic        capture_input_ch0_i,
	input  wire logic        capture_input_ch1_i,
	input  wire logic        capture_input_ch3_i,
	input  wire logic        capture_input_ch4_i,
	input  wire logic [3:0]  other_use_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [31:0]      rdata_o,
	output logic             irq_o,
	output logic [15:0]      hsc_budget_khz_o
);
	import pwpc_pkg::*;

	pwpc_ctrl_t  ctrl;
	pwpc_evt_t   status;
	pwpc_evt_t   mask;
	logic [4:0]  frac;
	logic [31:0] ring;
	logic        run_q;
	pwpc_vals_t  vals [NCH];
	logic [3:0]  done;
	logic [3:0]  range_hit;

	wire [3:0]   levels    = {capture_input_ch4_i, capture_input_ch3_i,
		capture_input_ch1_i, capture_input_ch0_i};
	// Interrupt use of a pin does not block capture, other claims do
	wire [3:0]   active    = ctrl.enable & ~other_use_i;
	wire         run_start = run_i & ~run_q;
	wire [5:0]   frac_sum  = {1'b0, frac} + {1'b0, TICK_STEP};
	wire         tick      = frac_sum >= {1'b0, TICK_MOD};
	wire [4:0]   next_frac = tick ? 5'(frac_sum - {1'b0, TICK_MOD}) : frac_sum[4:0];

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++)
		begin : g_chan
			pwpc_chan u_chan
			(
				.clock_i       (clock_i),
				.rst_n_i       (rst_n_i),
				.ce_i          (ce_i),
				.clear_i       (run_start),
				.active_i      (active[gi]),
				.period_mode_i (ctrl.period_mode[gi]),
				.level_i       (levels[gi]),
				.ring_i        (ring),
				.vals_o        (vals[gi]),
				.done_o        (done[gi]),
				.range_o       (range_hit[gi])
			);
		end
	endgenerate

	wire         wr_ctrl    = wr_i & (addr_i == OFS_CTRL);
	wire         wr_status  = wr_i & (addr_i == OFS_STATUS);
	wire         wr_mask    = wr_i & (addr_i == OFS_MASK);
	wire         in_chan    = addr_i < OFS_CTRL;
	wire [1:0]   ch_sel     = addr_i[6:5];
	wire [7:0]   ch_off     = addr_i & (CH_STRIDE - 8'h01);
	pwpc_vals_t  sel_vals;
	assign sel_vals = vals[ch_sel];

	pwpc_evt_t   evt_now;
	assign evt_now = '{
		range_err:    done & range_hit,
		conflict:     ctrl.enable & other_use_i,
		measure_flag: done
	};

	// Set beats the write-one clear so an event in the clearing cycle survives
	wire [11:0]  clr_bits    = wr_status ? wdata_i[11:0] : 12'h000;
	pwpc_evt_t   next_status;
	assign next_status = (status & ~clr_bits) | evt_now;
	pwpc_evt_t   next_mask;
	assign next_mask = wr_mask ? wdata_i[11:0] : mask;

	wire [2:0]   n_active    = 3'(active[0]) + 3'(active[1]) + 3'(active[2]) + 3'(active[3]);
	wire [15:0]  meas_load   = 16'(n_active) * MEAS_SHARE_KHZ;
	wire [15:0]  next_budget = (meas_load >= HSC_FULL_KHZ) ? 16'h0000
		: HSC_FULL_KHZ - meas_load;

	wire [31:0]  chan_word =
		(ch_off == OFS_RISE_LO) ? {16'h0000, sel_vals.rise[15:0]} :
		(ch_off == OFS_RISE_HI) ? {16'h0000, sel_vals.rise[31:16]} :
		(ch_off == OFS_FALL_LO) ? {16'h0000, sel_vals.fall[15:0]} :
		(ch_off == OFS_FALL_HI) ? {16'h0000, sel_vals.fall[31:16]} :
		(ch_off == OFS_RES_LO)  ? {16'h0000, sel_vals.result[15:0]} :
		(ch_off == OFS_RES_HI)  ? {16'h0000, sel_vals.result[31:16]} : 32'h0000_0000;
	wire [31:0]  read_val =
		in_chan                  ? chan_word :
		(addr_i == OFS_CTRL)     ? {24'h00_0000, ctrl} :
		(addr_i == OFS_STATUS)   ? {20'h0_0000, status} :
		(addr_i == OFS_MASK)     ? {20'h0_0000, mask} :
		(addr_i == OFS_BUDGET)   ? {16'h0000, hsc_budget_khz_o} : 32'h0000_0000;

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			frac <= 5'h00;
			ring <= 32'h0000_0000;
			run_q <= 1'b0;
		end
		else if (ce_i)
		begin
			frac <= next_frac;
			ring <= tick ? ring + 32'h0000_0001 : ring;
			run_q <= run_i;
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			ctrl             <= CTRL_RESET;
			status           <= EVT_RESET;
			mask             <= EVT_RESET;
			irq_o            <= 1'b0;
			rdata_o          <= 32'h0000_0000;
			hsc_budget_khz_o <= HSC_FULL_KHZ;
		end
		else if (ce_i)
		begin
			if (wr_ctrl)
				ctrl <= wdata_i[7:0];
			status           <= next_status;
			mask             <= next_mask;
			irq_o            <= |(next_status & next_mask);
			rdata_o          <= rd_i ? read_val : 32'h0000_0000;
			hsc_budget_khz_o <= next_budget;
		end
	end

	flag_set_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		ce_i && |done |=> (status.measure_flag & $past(done)) == $past(done))
		else $error("measure flag not set by new result");
	flag_keep_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		ce_i && done[0] && wr_status && wdata_i[0] |=> status.measure_flag[0])
		else $error("clear beat a new result");
	irq_level_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		irq_o |-> |(status & mask))
		else $error("interrupt without unmasked status");
	conflict_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		ce_i && |(ctrl.enable & other_use_i)
		|=> (status.conflict & $past(ctrl.enable & other_use_i))
			== $past(ctrl.enable & other_use_i))
		else $error("shared input not reported");
	budget_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		ce_i && active == 4'hF ##1 ce_i && active == 4'hF
		|=> hsc_budget_khz_o == ((HSC_FULL_KHZ < 16'(4) * MEAS_SHARE_KHZ) ? 16'h0000
			: HSC_FULL_KHZ - 16'(4) * MEAS_SHARE_KHZ))
		else $error("budget not reduced for active channels");
	read_slot_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		ce_i && !rd_i |=> rdata_o == 32'h0000_0000)
		else $error("read data outside its slot");
	ring_tick_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		ce_i && frac == 5'h00 ##1 ce_i [*8] |=> ring == $past(ring, 9) + 32'h0000_0001)
		else $error("ring counter rate wrong");

	width_done_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
		done[0] && !ctrl.period_mode[0]);
	period_done_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
		|(done & ctrl.period_mode));
	run_clear_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
		ce_i && run_start);
	irq_raise_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
		$rose(irq_o));
endmodule : pwpc_top

// ===== tb/pwpc_src.sv
`timescale 1ns/100ps
module pwpc_src
(
	input  wire logic       clock_i,
	output logic      [3:0] level_o
);
	// Sensor off between pulses, lines rest low
	initial level_o = 4'h0;

	// One channel at a time; each cycle stretched to 1000 clocks or more
	// so the summed input rate never exceeds 50 kHz
	task automatic pulse(input int ch, input int high_clk, input int period_clk);
		int rest;
		rest = ((period_clk < 1000) ? 1000 : period_clk) - high_clk;
		@(posedge clock_i);
		level_o[ch] <= 1'b1;
		repeat (high_clk) @(posedge clock_i);
		level_o[ch] <= 1'b0;
		repeat (rest) @(posedge clock_i);
	endtask : pulse
endmodule : pwpc_src

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import pwpc_pkg::*;
	localparam logic [15:0] FULL  = 16'h003C;
	localparam logic [15:0] SHARE = 16'h000A;
	logic        clock_i;
	logic        rst_n_i;
	logic        ce_i;
	logic        run_i;
	logic [3:0]  other_use_i;
	logic [7:0]  addr_i;
	logic [31:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [31:0] rdata_o;
	logic        irq_o;
	logic [15:0] hsc_budget_khz_o;
	logic [3:0]  level;
	logic [31:0] d;
	logic [31:0] r;
	logic [7:0]  base;
	int          num_errors;
	int          n_tests;
	int          ch;
	int          h;

	pwpc_src i_src (.clock_i(clock_i), .level_o(level));

	pwpc_top #(.HSC_FULL_KHZ(FULL), .MEAS_SHARE_KHZ(SHARE)) i_dut
	(
		.clock_i             (clock_i),
		.rst_n_i             (rst_n_i),
		.ce_i                (ce_i),
		.run_i               (run_i),
		.capture_input_ch0_i (level[0]),
		.capture_input_ch1_i (level[1]),
		.capture_input_ch3_i (level[2]),
		.capture_input_ch4_i (level[3]),
		.other_use_i         (other_use_i),
		.addr_i              (addr_i),
		.wdata_i             (wdata_i),
		.wr_i                (wr_i),
		.rd_i                (rd_i),
		.rdata_o             (rdata_o),
		.irq_o               (irq_o),
		.hsc_budget_khz_o    (hsc_budget_khz_o)
	);

	initial
	begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	function automatic int ticks_of(input int clk_n);
		return clk_n * 3 / 25;
	endfunction : ticks_of

	task automatic print_verdict;
		if (num_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %0h seen %0h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock_i);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge clock_i);
		wr_i    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clock_i);
		rd_i   <= 1'b0;
		#1 v = rdata_o;
	endtask : rd

	// Word pair: low half then high half, no snapshot
	task automatic rd32(input logic [7:0] a, output logic [31:0] v);
		logic [31:0] lo;
		logic [31:0] hi;
		rd(a, lo);
		rd(a + 8'h04, hi);
		v = {hi[15:0], lo[15:0]};
	endtask : rd32

	// Watchdog against a hung run
	initial
	begin
		repeat (100000) @(posedge clock_i);
		num_errors++;
		print_verdict();
	end

	initial
	begin
		rst_n_i = 1'b0;
		ce_i = 1'b1;
		run_i = 1'b0;
		other_use_i = 4'h0;
		addr_i = 8'h00;
		wdata_i = 32'h0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		num_errors = 0;
		n_tests = 0;
		void'($urandom(32'h4EC6));
		repeat (20) @(posedge clock_i);
		rst_n_i <= 1'b1;
		run_i <= 1'b1;
		rd(OFS_CTRL, d);
		chk("ctrl", 32'h0, d);
		rd(OFS_BUDGET, d);
		chk("budget", 32'(FULL), d);
		rd(8'hFC, d);
		chk("unmapped", 32'h0, d);
		wr(OFS_MASK, 32'h0000_0FFF);
		for (ch = 0; ch < NCH; ch++)
		begin
			base = 8'(ch) * CH_STRIDE;
			h = 500 * (1 + $urandom % 5) + 250;
			wr(OFS_CTRL, 32'h1 << ch);
			wr(OFS_STATUS, 32'h0000_0FFF);
			i_src.pulse(ch, h, h + 100);
			chk("irq", 32'h1, 32'(irq_o));
			rd(OFS_STATUS, d);
			chk("status", 32'h1 << ch, d);
			rd32(base + OFS_RES_LO, r);
			chk("width", 32'(ticks_of(h) / 60), r);
			rd32(base + OFS_RISE_LO, d);
			rd32(base + OFS_FALL_LO, r);
			chk("tick_span", 32'(ticks_of(h)), r - d);
			rd(OFS_BUDGET, d);
			chk("budget_one", 32'(FULL - SHARE), d);
			wr(OFS_STATUS, 32'h1 << ch);
			rd(OFS_STATUS, d);
			chk("status_clr", 32'h0, d);
			chk("irq_clr", 32'h0, 32'(irq_o));
		end
		// Clear lands in the very cycle the result arrives; the set must survive
		wr(OFS_CTRL, 32'h0000_0001);
		i_src.pulse(0, 1000, 1032);
		wr(OFS_STATUS, 32'h0000_0001);
		rd(OFS_STATUS, d);
		chk("flag_keep", 32'h1, 32'(d[0]));
		rd32(OFS_RES_LO, r);
		chk("width_keep", 32'(ticks_of(1000) / 60), r);
		ch = $urandom % 4;
		base = 8'(ch) * CH_STRIDE;
		h = 500 * (2 + $urandom % 4) + 250;
		wr(OFS_CTRL, (32'h11) << ch);
		i_src.pulse(ch, 100, h);
		i_src.pulse(ch, 100, h);
		rd32(base + OFS_RES_LO, r);
		chk("period", 32'(ticks_of(h) / 60), r);
		wr(OFS_CTRL, 32'h1 << ch);
		wr(OFS_STATUS, 32'h0000_0FFF);
		i_src.pulse(ch, 100, 1000);
		rd(OFS_STATUS, d);
		chk("range_err", 32'h1, 32'(d[8 + ch]));
		@(posedge clock_i);
		other_use_i[ch] <= 1'b1;
		wr(OFS_STATUS, 32'h0000_0FFF);
		i_src.pulse(ch, 800, 1000);
		rd(OFS_STATUS, d);
		chk("conflict", 32'h1, 32'(d[4 + ch]));
		chk("blocked", 32'h0, 32'(d[ch]));
		@(posedge clock_i);
		other_use_i[ch] <= 1'b0;
		wr(OFS_CTRL, 32'h0000_000F);
		rd(OFS_CTRL, d);
		chk("ctrl_rw", 32'h0000_000F, d);
		rd(OFS_BUDGET, d);
		chk("budget_all", 32'(FULL - 4 * SHARE), d);
		chk("budget_pin", 32'(FULL - 4 * SHARE), 32'(hsc_budget_khz_o));
		// Frozen clock enable must swallow a write
		@(posedge clock_i);
		ce_i <= 1'b0;
		wr(OFS_CTRL, 32'h0000_0000);
		ce_i <= 1'b1;
		rd(OFS_CTRL, d);
		chk("ctrl_frozen", 32'h0000_000F, d);
		@(posedge clock_i);
		run_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		run_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		for (ch = 0; ch < NCH; ch++)
		begin
			base = 8'(ch) * CH_STRIDE;
			rd32(base + OFS_RISE_LO, d);
			chk("rise_clr", 32'h0, d);
			rd32(base + OFS_FALL_LO, d);
			chk("fall_clr", 32'h0, d);
			rd32(base + OFS_RES_LO, d);
			chk("res_clr", 32'h0, d);
		end
		print_verdict();
	end
endmodule : tb_top
